// ### include/wrps_params.svh
// Purpose: constants of the receiver phase sequencer
// Assumes: 125 MHz clock
// Notes:   packet period counts are shortened in simulation through the module parameter
`ifndef WRPS_PARAMS_SVH
`define WRPS_PARAMS_SVH
`define WRPS_CLK_MHZ         125
`define WRPS_NEG_POWER_MW    16'h1388
`define WRPS_CAL_POINTS      2'h2
`define WRPS_CE_PERIOD_MS    250
`define WRPS_RP_PER_CE       8'h04
`define WRPS_CE_PERIOD_CYC   (`WRPS_CE_PERIOD_MS * 1000 * `WRPS_CLK_MHZ)
`endif

// ### include/wrps_pkg.sv
// Purpose: types of the receiver phase sequencer
// Assumes: nothing
// Notes:   none
package wrps_pkg;
   typedef enum logic [3:0] {
      WRPS_PKT_NONE,
      WRPS_PKT_SIG_STRENGTH,
      WRPS_PKT_IDENT,
      WRPS_PKT_CONFIG,
      WRPS_PKT_NEG_REQ,
      WRPS_PKT_CAL_LIGHT,
      WRPS_PKT_CAL_HEAVY,
      WRPS_PKT_CTRL_ERR,
      WRPS_PKT_RX_POWER
   } wrps_pkt_t;
   typedef enum logic [2:0] {
      WRPS_ST_OFF,
      WRPS_ST_PING,
      WRPS_ST_IDCFG,
      WRPS_ST_NEG,
      WRPS_ST_CAL,
      WRPS_ST_XFER
   } wrps_phase_t;
   typedef struct packed {
      logic        valid;
      wrps_pkt_t   kind;
      logic [15:0] payload;
   } wrps_tx_t;
endpackage

// ### design/wrps_sequencer.sv
// Purpose: receiver phase sequencer of an inductive power link
// Assumes: packet sender accepts one request at a time by tx_ready
// Notes:   one clock, synchronous reset
//          loss of the field aborts any phase and drops a pending request
//          medium power is looked at only when the configuration packet is taken
//          payloads are captured in the cycle a packet is issued, not when it is taken
//          the first periodic packet follows one full period after entering power transfer
// What this block does
// - on power up send signal strength
// - then send identification packet
// - then send configuration packet
// - medium power: negotiate above 5W
// - medium power: calibrate light and heavy load
// - power transfer: send control error packets
// - power transfer: periodic received power packets
`timescale 1ns/1ns
`default_nettype none
`include "wrps_params.svh"
module wrps_sequencer
#(
   parameter int unsigned CE_PERIOD_CYC = `WRPS_CE_PERIOD_CYC
)
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              field_ok,
   input  wire logic              medium_power,
   input  wire logic              tx_ready,
   input  wire logic              neg_granted,
   input  wire logic [15:0]       sig_strength,
   input  wire logic [15:0]       ident_word,
   input  wire logic [15:0]       config_word,
   input  wire logic [15:0]       ctrl_err,
   input  wire logic [15:0]       rx_power,
   output var  wrps_pkg::wrps_tx_t tx,
   output var  wrps_pkg::wrps_phase_t phase
);
   import wrps_pkg::*;

   // ****************************************
   // constants
   // ****************************************
   localparam logic [31:0] PERIOD_LAST = 32'(CE_PERIOD_CYC - 1);
   localparam logic [15:0] NEG_REQUEST = `WRPS_NEG_POWER_MW + 16'h0001;
   localparam logic [1:0]  CAL_LAST    = `WRPS_CAL_POINTS;
   localparam logic [7:0]  CE_LAST     = `WRPS_RP_PER_CE - 8'h01;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      wrps_phase_t phase;
      wrps_tx_t    tx;
      logic [1:0]  step;
      logic [31:0] timer;
      logic [7:0]  ce_count;
   } wrps_state_t;

   wrps_state_t s;
   wrps_state_t next_s;

   // ****************************************
   // outputs
   // ****************************************
   assign tx    = s.tx;
   assign phase = s.phase;

   // ****************************************
   // helpers
   // ****************************************
   // packet request with valid set
   function automatic wrps_tx_t make_pkt(input wrps_pkt_t k, input logic [15:0] d);
      wrps_tx_t p;
      p.valid   = 1'b1;
      p.kind    = k;
      p.payload = d;
      return p;
   endfunction

   // last cycle of a packet period
   function automatic logic period_done(input logic [31:0] t);
      return t >= PERIOD_LAST;
   endfunction

   // received power due instead of control error
   function automatic logic rp_due(input logic [7:0] n);
      return n >= CE_LAST;
   endfunction

   // entry to power transfer, period counters cleared
   function automatic wrps_state_t enter_xfer(input wrps_state_t cur);
      wrps_state_t n;
      n          = cur;
      n.phase    = WRPS_ST_XFER;
      n.timer    = '0;
      n.ce_count = 8'h00;
      return n;
   endfunction

   // one cycle of power transfer: count the period, then issue the periodic packet
   function automatic wrps_state_t xfer_step(input wrps_state_t cur, input logic [15:0] ce, input logic [15:0] rp);
      wrps_state_t n;
      n = cur;
      if (!period_done(cur.timer))
      begin
         n.timer = cur.timer + 32'h1;
      end
      else if (rp_due(cur.ce_count))
      begin
         n.timer    = '0;
         n.ce_count = 8'h00;
         n.tx       = make_pkt(WRPS_PKT_RX_POWER, rp);
      end
      else
      begin
         n.timer    = '0;
         n.ce_count = cur.ce_count + 8'h01;
         n.tx       = make_pkt(WRPS_PKT_CTRL_ERR, ce);
      end
      return n;
   endfunction

   // ****************************************
   // sequencing
   // ****************************************
   always_comb
   begin
      logic busy;
      logic accepted;
      // a taken request frees the slot, so the next one may follow at once
      accepted = s.tx.valid && tx_ready;
      busy     = s.tx.valid && !tx_ready;
      next_s   = s;
      if (accepted)
      begin
         next_s.tx.valid = 1'b0;
      end
      // field loss wins over any phase
      if (!field_ok)
      begin
         next_s       = '0;
         next_s.phase = WRPS_ST_OFF;
      end
      else if (!busy)
      begin
         unique case (s.phase)
            WRPS_ST_OFF:
            begin
               next_s.phase = WRPS_ST_PING;
               next_s.tx    = make_pkt(WRPS_PKT_SIG_STRENGTH, sig_strength);
            end
            WRPS_ST_PING:
            begin
               next_s.phase = WRPS_ST_IDCFG;
               next_s.step  = 2'h0;
               next_s.tx    = make_pkt(WRPS_PKT_IDENT, ident_word);
            end
            WRPS_ST_IDCFG:
            begin
               if (s.step == 2'h0)
               begin
                  next_s.step = 2'h1;
                  next_s.tx   = make_pkt(WRPS_PKT_CONFIG, config_word);
               end
               else if (medium_power)
               begin
                  next_s.phase = WRPS_ST_NEG;
                  next_s.step  = 2'h0;
                  next_s.tx    = make_pkt(WRPS_PKT_NEG_REQ, NEG_REQUEST);
               end
               else
               begin
                  next_s = enter_xfer(next_s);
               end
            end
            WRPS_ST_NEG:
            begin
               if (neg_granted)
               begin
                  next_s.phase = WRPS_ST_CAL;
                  next_s.step  = 2'h1;
                  next_s.tx    = make_pkt(WRPS_PKT_CAL_LIGHT, rx_power);
               end
            end
            WRPS_ST_CAL:
            begin
               if (s.step < CAL_LAST)
               begin
                  next_s.step = s.step + 2'h1;
                  next_s.tx   = make_pkt(WRPS_PKT_CAL_HEAVY, rx_power);
               end
               else
               begin
                  next_s = enter_xfer(next_s);
               end
            end
            WRPS_ST_XFER:
            begin
               next_s = xfer_step(next_s, ctrl_err, rx_power);
            end
            default:
            begin
               next_s.phase = WRPS_ST_OFF;
            end
         endcase
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end
endmodule
`default_nettype wire

// ### verif/wrps_asserts.sv
// Purpose: port checker of the sequencer
// Assumes: CE_PERIOD_CYC above 8
// Notes:   bound after the module
`timescale 1ns/1ns
`default_nettype none
module wrps_asserts
#(parameter int unsigned CE_PERIOD_CYC = 20)
(
   input wire logic                  clk,
   input wire logic                  rst,
   input wire logic                  field_ok,
   input wire logic                  medium_power,
   input wire logic                  tx_ready,
   input wire wrps_pkg::wrps_tx_t    tx,
   input wire wrps_pkg::wrps_phase_t phase
);
   import wrps_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire logic acc = tx.valid && tx_ready && field_ok;
   ping_start_a: assert property (phase == WRPS_ST_OFF && field_ok |=> tx.valid && tx.kind == WRPS_PKT_SIG_STRENGTH)
      else $error("no ping");
   field_loss_a: assert property (!field_ok |=> phase == WRPS_ST_OFF && !tx.valid)
      else $error("no abort");
   req_hold_a: assert property (tx.valid && !tx_ready ##1 field_ok |-> tx.valid && $stable(tx))
      else $error("dropped");
   idcfg_a: assert property (acc && tx.kind == WRPS_PKT_SIG_STRENGTH |=> phase == WRPS_ST_IDCFG)
      else $error("no idcfg");
   skip_neg_a: assert property (acc && tx.kind == WRPS_PKT_CONFIG |=> phase == (medium_power ? WRPS_ST_NEG : WRPS_ST_XFER))
      else $error("bad branch");
   neg_power_a: assert property (tx.valid && tx.kind == WRPS_PKT_NEG_REQ |-> tx.payload > 16'h1388)
      else $error("low request");
   cal_phase_a: assert property (tx.valid && tx.kind inside {WRPS_PKT_CAL_LIGHT, WRPS_PKT_CAL_HEAVY} |-> phase == WRPS_ST_CAL)
      else $error("cal phase");
   xfer_gap_a: assert property (acc && phase == WRPS_ST_XFER |=> !tx.valid [*8])
      else $error("too soon");
   cover property (acc && tx.kind == WRPS_PKT_CAL_HEAVY);
   cover property (acc && tx.kind == WRPS_PKT_RX_POWER);
   cover property (phase == WRPS_ST_XFER && !field_ok);
endmodule
bind wrps_sequencer wrps_asserts #(.CE_PERIOD_CYC(CE_PERIOD_CYC)) chk (.clk(clk), .rst(rst), .field_ok(field_ok),
   .medium_power(medium_power), .tx_ready(tx_ready), .tx(tx), .phase(phase));
`default_nettype wire

// ### verif/wrps_tx_model.sv
// Purpose: transmitter model taking packets
// Assumes: slow waits two cycles per packet
// Notes:   grants any negotiation request once taken, held until reset
`timescale 1ns/1ns
`default_nettype none
module wrps_tx_model
(
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               slow,
   input  wire wrps_pkg::wrps_tx_t tx,
   output logic                    tx_ready,
   output logic                    neg_granted,
   output logic [15:0]             cal_light,
   output logic [15:0]             cal_heavy
);
   import wrps_pkg::*;
   logic [1:0] wait_n;
   always_ff @(posedge clk)
   begin
      wait_n <= (rst || !tx.valid || tx_ready) ? {slow, 1'b0} : wait_n - {1'b0, wait_n != 2'h0};
      tx_ready <= !rst && tx.valid && !tx_ready && wait_n == 2'h0;
      neg_granted <= !rst && (neg_granted || tx.valid && tx_ready && tx.kind == WRPS_PKT_NEG_REQ);
      cal_light <= (tx.valid && tx_ready && tx.kind == WRPS_PKT_CAL_LIGHT) ? tx.payload : cal_light;
      cal_heavy <= (tx.valid && tx_ready && tx.kind == WRPS_PKT_CAL_HEAVY) ? tx.payload : cal_heavy;
   end
endmodule
`default_nettype wire

// ### verif/test_wireless_rx_phase_sequencer.sv
// Purpose: bench of the sequencer
// Assumes: period cut to 20 cycles
// Notes:   direct and medium runs, the medium run ending with field loss, field return and a new signal strength packet
`timescale 1ns/1ns
`default_nettype none
module test_wireless_rx_phase_sequencer;
   import wrps_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, field_ok = 1'b0, medium_power = 1'b0, slow = 1'b0, tx_ready, neg_granted;
   wrps_tx_t    tx;
   wrps_phase_t phase;
   logic [15:0] rx_power = 16'h0e55;
   logic [15:0] cal_light;
   logic [15:0] cal_heavy;
   int          n_fail = 0, n_tests = 0;
   wrps_sequencer #(.CE_PERIOD_CYC(20)) dut (.clk(clk), .rst(rst), .field_ok(field_ok), .medium_power(medium_power),
      .tx_ready(tx_ready), .neg_granted(neg_granted), .sig_strength(16'h0a51), .ident_word(16'h0b52),
      .config_word(16'h0c53), .ctrl_err(16'h0d54), .rx_power(rx_power), .tx(tx), .phase(phase));
   wrps_tx_model pm (.clk(clk), .rst(rst), .slow(slow), .tx(tx), .tx_ready(tx_ready), .neg_granted(neg_granted),
      .cal_light(cal_light), .cal_heavy(cal_heavy));
   initial
   begin
      forever #4 clk = ~clk;
   end
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_payload(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic pkt(input wrps_pkt_t k, input logic [15:0] pay);
      int i;
      for (i = 0; i < 99 && !(tx.valid === 1'b1 && tx_ready === 1'b1); i++)
         @(negedge clk);
      if (i == 99)
      begin
         n_fail++;
         $display("CHECK FAILED accept expected %h seen %h", 8'(k), 8'(tx.kind));
         complete_run();
      end
      else
      begin
         check("kind", 8'(k), 8'(tx.kind));
         check_payload("payload", pay, tx.payload);
         @(negedge clk);
      end
   endtask
   task automatic start(input logic med, input logic slw);
      @(posedge clk);
      rst <= 1'b1;
      medium_power <= med;
      slow <= slw;
      rx_power <= 16'h0e55;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      field_ok <= 1'b1;
   endtask
   task automatic run_direct();
      start(1'b0, 1'b0);
      pkt(WRPS_PKT_SIG_STRENGTH, 16'h0a51);
      pkt(WRPS_PKT_IDENT, 16'h0b52);
      pkt(WRPS_PKT_CONFIG, 16'h0c53);
      pkt(WRPS_PKT_CTRL_ERR, 16'h0d54);
      check("phase", 8'(WRPS_ST_XFER), 8'(phase));
      repeat (2) pkt(WRPS_PKT_CTRL_ERR, 16'h0d54);
      pkt(WRPS_PKT_RX_POWER, 16'h0e55);
   endtask
   task automatic run_medium();
      start(1'b1, 1'b1);
      pkt(WRPS_PKT_SIG_STRENGTH, 16'h0a51);
      pkt(WRPS_PKT_IDENT, 16'h0b52);
      pkt(WRPS_PKT_CONFIG, 16'h0c53);
      pkt(WRPS_PKT_NEG_REQ, 16'h1389);
      @(posedge clk);
      rx_power <= 16'h0f56;
      pkt(WRPS_PKT_CAL_LIGHT, 16'h0e55);
      pkt(WRPS_PKT_CAL_HEAVY, 16'h0f56);
      check_payload("cal light", 16'h0e55, cal_light);
      check_payload("cal heavy", 16'h0f56, cal_heavy);
      pkt(WRPS_PKT_CTRL_ERR, 16'h0d54);
      @(posedge clk);
      field_ok <= 1'b0;
      repeat (2) @(negedge clk);
      check("phase", 8'(WRPS_ST_OFF), 8'(phase));
      check("valid", 8'h0, 8'(tx.valid));
      @(posedge clk);
      field_ok <= 1'b1;
      pkt(WRPS_PKT_SIG_STRENGTH, 16'h0a51);
   endtask
   initial
   begin
      run_direct();
      run_medium();
      complete_run();
   end
endmodule
`default_nettype wire
